// ### rtl/usb_channel_word.v
// One host channel control word with its enable handshake.
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_port_channel_ctrl_defines.vh"

module usb_channel_word (
  input  wire        clk,        // System clock.
  input  wire        nrst,       // Asynchronous reset, active low.
  input  wire        wr_en,      // Whole-word write to this channel.
  input  wire [31:0] wdata,      // Write data.
  input  wire        halt_done,  // Engine has stopped this channel.
  input  wire        frame_odd,  // Current frame number is odd.
  input  wire        port_ready, // Port enabled, not suspended and not in bus reset.
  output reg  [31:0] ctl_word,   // Stored control word.
  output reg         eligible    // Channel may be scheduled now.
);

  // ==========================================================
  // Next-state logic.
  reg  [31:0] next_ctl;   // Next control word.
  wire        periodic;   // Interrupt or isochronous kind.
  wire        parity_ok;  // Frame parity matches selection.

  // Periodic kinds are isochronous and interrupt.
  assign periodic = (next_ctl[`CH_KIND_HI:`CH_KIND_LO] == `KIND_ISO) ||
                    (next_ctl[`CH_KIND_HI:`CH_KIND_LO] == `KIND_INTR);
  // Periodic work waits for the chosen even or odd frame.
  assign parity_ok = !periodic || (next_ctl[`CH_PAR_BIT] == frame_odd);

  // Field update; on and stop bits are set-only from software.
  always @* begin
    next_ctl = ctl_word;
    if (halt_done) begin
      // The engine reports the halt, so the handshake closes.
      next_ctl[`CH_ON_BIT]   = 1'b0;
      next_ctl[`CH_STOP_BIT] = 1'b0;
    end
    if (wr_en) begin
      // Parity, address, kind, speed, direction, endpoint, length fields.
      next_ctl = (next_ctl & ~`CH_RW_MASK) | (wdata & `CH_RW_MASK);
      // A software set wins over a halt in the same cycle.
      if (wdata[`CH_ON_BIT]) begin
        next_ctl[`CH_ON_BIT] = 1'b1;
      end
      // A stop request only makes sense on a running channel.
      if (wdata[`CH_STOP_BIT] && next_ctl[`CH_ON_BIT]) begin
        next_ctl[`CH_STOP_BIT] = 1'b1;
      end
    end
  end

  // ==========================================================
  // State registers.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_word <= `CH_RESET;
      eligible <= 1'b0;
    end else begin
      ctl_word <= next_ctl;
      // A stopping channel takes no new transactions.
      eligible <= next_ctl[`CH_ON_BIT] && !next_ctl[`CH_STOP_BIT] &&
                  port_ready && parity_ok;
    end
  end

endmodule
`default_nettype wire

// ### rtl/usb_host_port_channel_ctrl.v
// Host port control and status plus channel control words on AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_port_channel_ctrl_defines.vh"

module usb_host_port_channel_ctrl #(
  parameter CHANNELS = 8,  // Number of host channels.
  parameter AW       = 12  // Decoded address bits.
) (
  input  wire                   clk,             // System clock, 20 MHz.
  input  wire                   nrst,            // Asynchronous reset, active low.
  input  wire                   hsel,            // Slave select.
  input  wire [31:0]            haddr,           // Byte address.
  input  wire [1:0]             htrans,          // Transfer type.
  input  wire                   hwrite,          // Write when high.
  input  wire [2:0]             hsize,           // Transfer size.
  input  wire [31:0]            hwdata,          // Write data.
  input  wire                   hready,          // Bus ready.
  output reg  [31:0]            hrdata,          // Read data.
  output reg                    hreadyout,       // Slave ready.
  output reg                    hresp,           // Slave response.
  input  wire                   conn_sense,      // A device is on the port.
  input  wire                   remote_wakeup,   // Wakeup seen on the bus.
  input  wire                   frame_odd,       // Current frame is odd.
  input  wire [CHANNELS-1:0]    chan_halt_done,  // Engine halted channel.
  output reg                    sof_enable,      // Start-of-frame tokens allowed.
  output reg                    drive_resume,    // Drive resume signalling.
  output reg                    drive_reset,     // Drive bus reset signalling.
  output reg                    port_event_flag, // Sticky port event.
  output wire [CHANNELS*32-1:0] chan_ctl,        // All channel words.
  output wire [CHANNELS-1:0]    chan_eligible    // Channels ready to run.
);

  // ==========================================================
  // Address decode helpers.

  // True when an address hits the control word of a channel.
  function chan_hit;
    input [AW-1:0] addr;
    input integer  idx;
    reg   [AW-1:0] base;
    begin
      base     = `CHAN_BASE + idx[AW-1:0] * `CHAN_STRIDE;
      chan_hit = (addr == base);
    end
  endfunction

  // ==========================================================
  // Bus address phase capture.
  reg           wr_pend;   // Write data phase is due.
  reg  [AW-1:0] wr_addr;   // Latched write address.
  reg           wr_word;   // Latched write was a whole word.
  wire          take;      // Address phase accepted this edge.
  wire          take_word; // Accepted phase is a whole word.

  // An access is taken when selected, active and the bus is ready.
  assign take      = hsel && htrans[1] && hready;
  // Narrower accesses are ignored and read as zero.
  assign take_word = (hsize == `HSIZE_WORD);

  // Latches each write so its data can be applied next cycle.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_word <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_addr <= haddr[AW-1:0];
        wr_word <= take_word;
      end
    end
  end

  // ==========================================================
  // Write strobes.
  wire port_wr;   // Write to the port register.
  wire event_wr;  // Write to the event register.

  assign port_wr  = wr_pend && wr_word && (wr_addr == `PORT_OFF);
  assign event_wr = wr_pend && wr_word && (wr_addr == `EVENT_OFF);

  // ==========================================================
  // Port state.
  reg  port_attached;      // Live connection state.
  reg  port_attach_seen;   // Sticky connect flag.
  reg  port_enabled;       // Port enabled.
  reg  port_enable_change; // Sticky enable change flag.
  reg  port_suspend;       // Port suspended.
  reg  port_resume;        // Resume bit.
  reg  port_reset_drive;   // Reset bit.
  wire connect_edge;       // Device just attached.
  wire disconnect_edge;    // Device just detached.
  wire reset_finish;       // Software ends bus reset.
  wire reset_start;        // Software starts bus reset.

  // The sensed level is synchronous; edges come from the last value.
  assign connect_edge    = conn_sense && !port_attached;
  assign disconnect_edge = !conn_sense && port_attached;
  assign reset_start     = port_wr && hwdata[`PORT_RST_BIT] && !port_reset_drive;
  assign reset_finish    = port_wr && !hwdata[`PORT_RST_BIT] && port_reset_drive;

  // Next values of the port bits.
  reg next_enabled;  // Next enabled bit.
  reg next_suspend;  // Next suspend bit.
  reg next_change;   // Next enable change flag.
  reg next_seen;     // Next attach flag.
  reg next_event;    // Next port event flag.
  reg next_resume;   // Next resume bit.
  reg next_reset;    // Next reset bit.

  // Combines bus writes with link events for the enable, suspend and flag bits.
  always @* begin
    // Reset and resume bits simply follow software.
    next_reset  = port_reset_drive;
    next_resume = port_resume;
    if (port_wr) begin
      next_reset  = hwdata[`PORT_RST_BIT];
      next_resume = hwdata[`PORT_RSM_BIT];
    end

    // Enabled: only the end of bus reset sets it.
    next_enabled = port_enabled;
    if (port_wr && hwdata[`PORT_EN_BIT]) begin
      // Writing one clears; software can never set it.
      next_enabled = 1'b0;
    end
    if (reset_finish && conn_sense) begin
      next_enabled = 1'b1;
    end
    if (disconnect_edge || !conn_sense) begin
      next_enabled = 1'b0;
    end

    // Suspend: software sets it, only listed events clear it.
    next_suspend = port_suspend;
    if (port_wr && hwdata[`PORT_SUSP_BIT]) begin
      next_suspend = 1'b1;
    end
    if ((port_wr && hwdata[`PORT_RST_BIT]) || next_resume ||
        remote_wakeup || disconnect_edge) begin
      next_suspend = 1'b0;
    end

    // Enable change: write one clears, a change sets and wins.
    next_change = port_enable_change;
    if (port_wr && hwdata[`PORT_CHG_BIT]) begin
      next_change = 1'b0;
    end
    if (next_enabled != port_enabled) begin
      next_change = 1'b1;
    end

    // Attach seen: write one clears, a connect sets and wins.
    next_seen = port_attach_seen;
    if (port_wr && hwdata[`PORT_SEEN_BIT]) begin
      next_seen = 1'b0;
    end
    if (connect_edge) begin
      next_seen = 1'b1;
    end

    // Port event: sticky, write one clears, any set wins.
    next_event = port_event_flag;
    if (event_wr && hwdata[`EVENT_BIT]) begin
      next_event = 1'b0;
    end
    if (reset_start || (next_enabled != port_enabled) || connect_edge) begin
      next_event = 1'b1;
    end
  end

  // Port registers and the outputs that face the link.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_attached      <= 1'b0;
      port_attach_seen   <= 1'b0;
      port_enabled       <= 1'b0;
      port_enable_change <= 1'b0;
      port_suspend       <= 1'b0;
      port_resume        <= 1'b0;
      port_reset_drive   <= 1'b0;
      port_event_flag    <= 1'b0;
      sof_enable         <= 1'b0;
      drive_resume       <= 1'b0;
      drive_reset        <= 1'b0;
    end else begin
      port_attached      <= conn_sense;
      port_attach_seen   <= next_seen;
      port_enabled       <= next_enabled;
      port_enable_change <= next_change;
      port_suspend       <= next_suspend;
      port_resume        <= next_resume;
      port_reset_drive   <= next_reset;
      port_event_flag    <= next_event;
      // Frames run only on an enabled port outside suspend and reset.
      sof_enable   <= next_enabled && !next_suspend && !next_reset;
      drive_resume <= next_resume;
      drive_reset  <= next_reset;
    end
  end

  // ==========================================================
  // Channel control words.
  wire [CHANNELS-1:0] chan_wr;     // Per-channel write strobe.
  wire                port_ready;  // Port can carry traffic.

  // Channels only run while frames are being sent.
  assign port_ready = sof_enable;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      // Whole-word writes only reach a channel word.
      assign chan_wr[g] = wr_pend && wr_word && chan_hit(wr_addr, g);

      // One control word and handshake per channel.
      usb_channel_word u_word (
        .clk        (clk),
        .nrst       (nrst),
        .wr_en      (chan_wr[g]),
        .wdata      (hwdata),
        .halt_done  (chan_halt_done[g]),
        .frame_odd  (frame_odd),
        .port_ready (port_ready),
        .ctl_word   (chan_ctl[g*32 +: 32]),
        .eligible   (chan_eligible[g])
      );
    end
  endgenerate

  // ==========================================================
  // Read path.
  reg [31:0] next_rdata;  // Read data for the accepted phase.
  reg [31:0] port_word;   // Assembled port register.
  integer    i;           // Channel loop index.

  // Builds the word that a read of the current address phase (haddr) returns.
  always @* begin
    port_word = 32'h00000000;
    port_word[`PORT_RST_BIT]  = port_reset_drive;
    port_word[`PORT_SUSP_BIT] = port_suspend;
    port_word[`PORT_RSM_BIT]  = port_resume;
    port_word[`PORT_CHG_BIT]  = port_enable_change;
    port_word[`PORT_EN_BIT]   = port_enabled;
    port_word[`PORT_SEEN_BIT] = port_attach_seen;
    port_word[`PORT_ATT_BIT]  = port_attached;
    next_rdata = 32'h00000000;
    if (!take_word) begin
      // Narrow reads see zero.
      next_rdata = 32'h00000000;
    end else if (haddr[AW-1:0] == `PORT_OFF) begin
      next_rdata = port_word;
    end else if (haddr[AW-1:0] == `EVENT_OFF) begin
      next_rdata[`EVENT_BIT] = port_event_flag;
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (chan_hit(haddr[AW-1:0], i)) begin
          next_rdata = chan_ctl[i*32 +: 32];
        end
      end
    end
  end

  // Read data is captured at the address phase; no wait states.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      if (take && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/usb_host_port_channel_ctrl_defines.vh
// Constants shared by the host port and channel control logic.
`ifndef USB_HOST_PORT_CHANNEL_CTRL_DEFINES_VH
`define USB_HOST_PORT_CHANNEL_CTRL_DEFINES_VH

// ==========================================================
// Register byte offsets.
`define EVENT_OFF      12'h014
`define PORT_OFF       12'h440
`define CHAN_BASE      12'h500
`define CHAN_STRIDE    12'h020
`define CHAN_WORD_OFF  5'h00

// ==========================================================
// Port control and status bit positions.
`define PORT_RST_BIT   8
`define PORT_SUSP_BIT  7
`define PORT_RSM_BIT   6
`define PORT_CHG_BIT   3
`define PORT_EN_BIT    2
`define PORT_SEEN_BIT  1
`define PORT_ATT_BIT   0
`define EVENT_BIT      0

// ==========================================================
// Channel control word fields.
`define CH_ON_BIT      31
`define CH_STOP_BIT    30
`define CH_PAR_BIT     29
`define CH_ADDR_HI     28
`define CH_ADDR_LO     22
`define CH_KIND_HI     19
`define CH_KIND_LO     18
`define CH_SLOW_BIT    17
`define CH_DIR_BIT     15
`define CH_EP_HI       14
`define CH_EP_LO       11
`define CH_MPL_HI      10
`define CH_MPL_LO      0
`define CH_RW_MASK     32'h3FCEFFFF
`define CH_RESET       32'h00000000
`define KIND_CONTROL   2'h0
`define KIND_ISO       2'h1
`define KIND_BULK      2'h2
`define KIND_INTR      2'h3

// ==========================================================
// Bus encodings.
`define HSIZE_WORD     3'h2
`define HRESP_OKAY     1'h0

`endif

// ### testbench/tb_usb_host_port_channel_ctrl.sv
// Self-checking bench for the host port and channel control block.
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_port_channel_ctrl_defines.vh"
module tb_usb_host_port_channel_ctrl;
  logic        clk, nrst, hsel, hwrite, frame_odd, plug, wake_req;  // Single-bit drives.
  logic [1:0]  htrans;                                              // Transfer type.
  logic [2:0]  hsize;                                               // Transfer size.
  logic [31:0] haddr, hwdata, hrdata, rd;                           // Bus words.
  logic [7:0]  halt, chan_eligible, reset_cycles;                   // Channel and model vectors.
  logic        hreadyout, hresp, conn_sense, remote_wakeup;         // Design and model outputs.
  logic        sof_enable, drive_resume, drive_reset, port_event_flag;
  logic [255:0] chan_ctl;                                           // All channel words.
  int          error_cnt, n_compared, cyc;                          // Counters.
  wire         hready = hreadyout;                                  // One slave on the bus.
  // Channel rows: address, data written and word read back; bit 31 stays clear.
  logic [95:0] rows [4] = '{96'h00000500_7FF3FFFF_3FC2FFFF, 96'h00000520_00458123_00448123,
                            96'h000005C0_2AB88A55_2A888A55, 96'h000005E0_1F3C7A5A_1F0C7A5A};
  usb_host_port_channel_ctrl u_usb_host_port_channel_ctrl (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conn_sense(conn_sense),
    .remote_wakeup(remote_wakeup), .frame_odd(frame_odd), .chan_halt_done(halt), .sof_enable(sof_enable),
    .drive_resume(drive_resume), .drive_reset(drive_reset), .port_event_flag(port_event_flag),
    .chan_ctl(chan_ctl), .chan_eligible(chan_eligible));
  usb_attached_device u_usb_attached_device (.clk(clk), .nrst(nrst), .plug(plug), .wake_req(wake_req),
    .sof_enable(sof_enable), .drive_reset(drive_reset), .conn_sense(conn_sense),
    .remote_wakeup(remote_wakeup), .reset_cycles(reset_cycles));
  // ==========================================================
  // Clock at 50 ns and a cycle ceiling against hangs.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      conclude();
    end
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB-Lite single transfer; the result settles before return.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'h1, a, d, `HSIZE_WORD);
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0, `HSIZE_WORD);
    chk(what, exp, rd);
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    {clk, nrst, hwrite, frame_odd, plug, wake_req} = 6'h00;
    hsel = 1'h1;
    htrans = 2'h0;
    hsize = `HSIZE_WORD;
    {haddr, hwdata, halt} = 72'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    rdchk("port reset value", `PORT_OFF, 32'h0);
    rdchk("event reset value", `EVENT_OFF, 32'h0);
    rdchk("unmapped read", 32'h100, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i][95:64], rows[i][63:32]);
      rdchk("channel word", rows[i][95:64], rows[i][31:0]);
      chk("channel port", rows[i][31:0], chan_ctl[rows[i][71:69]*32 +: 32]);
    end
    @(posedge clk) plug <= 1'h1;
    repeat (3) tick;
    chk("event after attach", 32'h1, port_event_flag);
    rdchk("port after attach", `PORT_OFF, 32'h3);
    ahb(1'h0, `PORT_OFF, 32'h0, 3'h0);
    chk("byte read", 32'h0, rd);
    wr(`EVENT_OFF, 32'h1);
    chk("event cleared", 32'h0, port_event_flag);
    wr(`PORT_OFF, 32'h6);
    rdchk("enable not set by write", `PORT_OFF, 32'h1);
    wr(`PORT_OFF, 32'h100);
    chk("drive reset", 32'h1, drive_reset);
    chk("event on reset", 32'h1, port_event_flag);
    repeat (10) @(posedge clk);
    wr(`PORT_OFF, 32'h0);
    chk("reset length", 32'hD, reset_cycles);
    chk("frames after reset", 32'h1, sof_enable);
    rdchk("port enabled", `PORT_OFF, 32'hD);
    wr(`PORT_OFF, 32'h8);
    rdchk("change cleared", `PORT_OFF, 32'h5);
    for (int k = 0; k < 4; k++) begin
      wr(32'h520, 32'hA0000000 | (32'(k) << 18));
      tick;
      chk("eligible in even frame", k % 2 == 0, chan_eligible[1]);
      @(posedge clk) frame_odd <= 1'h1;
      repeat (2) tick;
      chk("eligible in odd frame", 32'h1, chan_eligible[1]);
      wr(32'h520, 32'hE0000000 | (32'(k) << 18));
      tick;
      chk("stopped not eligible", 32'h0, chan_eligible[1]);
      @(posedge clk) frame_odd <= 1'h0;
      halt <= 8'h02;
      @(posedge clk) halt <= 8'h00;
      rdchk("channel after halt", 32'h520, 32'h20000000 | (32'(k) << 18));
    end
    wr(`PORT_OFF, 32'h80);
    tick;
    chk("no frames in suspend", 32'h0, sof_enable);
    rdchk("port suspended", `PORT_OFF, 32'h85);
    @(posedge clk) wake_req <= 1'h1;
    repeat (3) tick;
    @(posedge clk) wake_req <= 1'h0;
    rdchk("wakeup ends suspend", `PORT_OFF, 32'h5);
    chk("frames after wakeup", 32'h1, sof_enable);
    wr(`PORT_OFF, 32'h80);
    wr(`PORT_OFF, 32'h40);
    chk("resume driven", 32'h1, drive_resume);
    rdchk("resume ends suspend", `PORT_OFF, 32'h45);
    wr(`PORT_OFF, 32'h0);
    chk("resume stopped", 32'h0, drive_resume);
    wr(`PORT_OFF, 32'h4);
    rdchk("software disable", `PORT_OFF, 32'h9);
    // Suspend again, so that the detach must also end the suspend.
    wr(`PORT_OFF, 32'h80);
    @(posedge clk) plug <= 1'h0;
    repeat (3) tick;
    rdchk("port after detach", `PORT_OFF, 32'h8);
    // Mid-run reset: flags, channel words and read data return to zero.
    @(posedge clk) nrst <= 1'h0;
    tick;
    chk("reset clears event", 32'h0, port_event_flag);
    chk("reset clears channel", 32'h0, chan_ctl[63:32]);
    chk("reset clears read data", 32'h0, hrdata);
    @(posedge clk) nrst <= 1'h1;
    rdchk("port after mid reset", `PORT_OFF, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// ### testbench/usb_attached_device.sv
// Behavioural model of the device attached to the host port.
`timescale 1ns/1ps
`default_nettype none
module usb_attached_device (
  input  wire logic       clk,           // System clock.
  input  wire logic       nrst,          // Reset, active low.
  input  wire logic       plug,          // Bench request to attach.
  input  wire logic       wake_req,      // Bench request for wakeup.
  input  wire logic       sof_enable,    // Host is sending frames.
  input  wire logic       drive_reset,   // Host drives bus reset.
  output logic            conn_sense,    // Device seen on the port.
  output logic            remote_wakeup, // Wakeup signalling.
  output logic [7:0]      reset_cycles   // Cycles of bus reset seen.
);
  // ==========================================================
  // Attach follows the plug; wakeup only while frames have stopped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conn_sense    <= 1'h0;
      remote_wakeup <= 1'h0;
      reset_cycles  <= 8'h00;
    end else begin
      conn_sense    <= plug;
      remote_wakeup <= wake_req & ~sof_enable;
      if (drive_reset) begin
        reset_cycles <= reset_cycles + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/usb_host_port_channel_ctrl_properties.sv
// Concurrent checks on the ports of the host port and channel control block.
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_port_channel_ctrl_defines.vh"
module usb_host_port_channel_ctrl_properties #(
  parameter CHANNELS = 8  // Number of host channels.
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   conn_sense,
  input wire logic                   frame_odd,
  input wire logic [CHANNELS-1:0]    chan_halt_done,
  input wire logic                   sof_enable,
  input wire logic                   drive_reset,
  input wire logic                   port_event_flag,
  input wire logic [CHANNELS*32-1:0] chan_ctl,
  input wire logic [CHANNELS-1:0]    chan_eligible
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr1;     // Data phase of a word write to channel 1.
  logic rd_bad;  // Data phase of a read that is not a whole word.
  // ==========================================================
  // Tracks which data phase is under way.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr1    <= 1'h0;
      rd_bad <= 1'h0;
    end else begin
      wr1    <= hsel & htrans[1] & hready & hwrite & (haddr[11:0] == 12'h520) & (hsize == `HSIZE_WORD);
      rd_bad <= hsel & htrans[1] & hready & !hwrite & (hsize != `HSIZE_WORD);
    end
  end
  a_bus_okay: assert property (hreadyout && hresp == `HRESP_OKAY) else $error("bus not ready or not okay");
  a_refused_read: assert property (rd_bad |-> hrdata == 32'h0) else $error("part-word read not zero");
  a_word_write: assert property (wr1 |=>
    {2'h0, chan_ctl[61:32]} == ($past(hwdata) & `CH_RW_MASK)) else $error("channel fields not stored");
  a_halt_clears: assert property (chan_halt_done[1] && !wr1 |=> !chan_ctl[63] && !chan_ctl[62])
    else $error("halt left channel on");
  a_eligible_on: assert property (chan_eligible[1] |-> chan_ctl[63] || $past(chan_ctl[63]))
    else $error("eligible while channel off");
  a_parity_frame: assert property (chan_eligible[1] && $past(chan_ctl[50])
    && $stable(frame_odd) && $stable(chan_ctl[63:32]) |-> chan_ctl[61] == frame_odd)
    else $error("periodic in wrong frame");
  a_reset_nosof: assert property (drive_reset && $past(drive_reset) |-> !sof_enable)
    else $error("frames during bus reset");
  a_reset_event: assert property ($rose(drive_reset) |-> port_event_flag) else $error("no event on reset");
  a_connect_event: assert property ($rose(conn_sense) |=> port_event_flag)
    else $error("no event on attach");
  a_detach_nosof: assert property (!conn_sense [*2] |=> !sof_enable) else $error("frames while detached");
  a_enable_after: assert property ($fell(drive_reset) && $past(conn_sense)
    |-> sof_enable && port_event_flag) else $error("port not enabled after reset");
  c_reset_done: cover property ($fell(drive_reset));
  c_eligible: cover property (chan_eligible[1]);
  c_refused: cover property (rd_bad);
endmodule
bind usb_host_port_channel_ctrl usb_host_port_channel_ctrl_properties #(.CHANNELS(CHANNELS)) u_props (
  .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .conn_sense(conn_sense), .frame_odd(frame_odd), .chan_halt_done(chan_halt_done),
  .sof_enable(sof_enable), .drive_reset(drive_reset), .port_event_flag(port_event_flag),
  .chan_ctl(chan_ctl), .chan_eligible(chan_eligible));
`default_nettype wire
